// file: core/boundary_scan_test_port.sv
`timescale 1ns/10ps
module boundary_scan_test_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic [scan_port_pkg::CHAIN_INPUTS-1:0] func_in,
    input wire logic [scan_port_pkg::CHAIN_OUTPUTS-1:0] core_out,
    output logic [scan_port_pkg::CHAIN_OUTPUTS-1:0] pin_out,
    output logic pin_oe_n,
    output logic tdo,
    output logic tdo_oe_n
);
    localparam int NI = scan_port_pkg::CHAIN_INPUTS;
    localparam int NO = scan_port_pkg::CHAIN_OUTPUTS;

    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] tck_sync, tms_sync, tdi_sync, trst_sync;
    logic tck_prev;
    logic rise, fall;
    scan_port_pkg::tap_state_type state, next_state;
    logic [3:0] instruction_shift_reg;
    logic [3:0] instr;
    logic single_bit_pass_reg;
    logic [31:0] identification_shift_reg;
    logic chain_so;
    logic [scan_port_pkg::CHAIN_LENGTH-1:0] chain_held;
    logic sel_chain, sel_id, drive_cells;
    logic serial_bit;
    logic [NI-1:0] func_meta, func_sync;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Link pins are asynchronous to clk; two stages before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h0;
            trst_sync <= 2'h0;
            tck_prev <= 1'b0;
        end else begin
            tck_sync <= {tck_sync[0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            trst_sync <= {trst_sync[0], trst_n};
            tck_prev <= tck_sync[1];
        end
    end
    // Edge detect; test clock must be far slower than clk
    assign rise = tck_sync[1] & ~tck_prev;
    assign fall = ~tck_sync[1] & tck_prev;

    // Functional input pins belong to another clock; two stages first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_meta <= '0;
            func_sync <= '0;
        end else begin
            func_meta <= func_in;
            func_sync <= func_meta;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            scan_port_pkg::TEST_LOGIC_RESET: next_state = tms_sync[1] ?
                scan_port_pkg::TEST_LOGIC_RESET : scan_port_pkg::RUN_IDLE;
            scan_port_pkg::RUN_IDLE: next_state = tms_sync[1] ?
                scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_IDLE;
            scan_port_pkg::SELECT_DR: next_state = tms_sync[1] ?
                scan_port_pkg::SELECT_INSTR : scan_port_pkg::CAPTURE_DR;
            scan_port_pkg::CAPTURE_DR: next_state = tms_sync[1] ?
                scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
            scan_port_pkg::SHIFT_DR: next_state = tms_sync[1] ?
                scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
            scan_port_pkg::EXIT1_DR: next_state = tms_sync[1] ?
                scan_port_pkg::UPDATE_DR : scan_port_pkg::PAUSE_DR;
            scan_port_pkg::PAUSE_DR: next_state = tms_sync[1] ?
                scan_port_pkg::EXIT2_DR : scan_port_pkg::PAUSE_DR;
            scan_port_pkg::EXIT2_DR: next_state = tms_sync[1] ?
                scan_port_pkg::UPDATE_DR : scan_port_pkg::SHIFT_DR;
            scan_port_pkg::UPDATE_DR: next_state = tms_sync[1] ?
                scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_IDLE;
            scan_port_pkg::SELECT_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::TEST_LOGIC_RESET : scan_port_pkg::CAPTURE_INSTR;
            scan_port_pkg::CAPTURE_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::EXIT1_INSTR : scan_port_pkg::SHIFT_INSTR;
            scan_port_pkg::SHIFT_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::EXIT1_INSTR : scan_port_pkg::SHIFT_INSTR;
            scan_port_pkg::EXIT1_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::UPDATE_INSTR : scan_port_pkg::PAUSE_INSTR;
            scan_port_pkg::PAUSE_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::EXIT2_INSTR : scan_port_pkg::PAUSE_INSTR;
            scan_port_pkg::EXIT2_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::UPDATE_INSTR : scan_port_pkg::SHIFT_INSTR;
            scan_port_pkg::UPDATE_INSTR: next_state = tms_sync[1] ?
                scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_IDLE;
        endcase
    end

    // State advances on rising test clock; test reset forces home
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= scan_port_pkg::TEST_LOGIC_RESET;
        end else if (!trst_sync[1]) begin
            state <= scan_port_pkg::TEST_LOGIC_RESET;
        end else if (rise) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instruction_shift_reg <= scan_port_pkg::INSTR_RESET;
            instr <= scan_port_pkg::INSTR_RESET;
        end else if (state == scan_port_pkg::TEST_LOGIC_RESET) begin
            instruction_shift_reg <= scan_port_pkg::INSTR_RESET;
            instr <= scan_port_pkg::INSTR_RESET;
        end else if (rise) begin
            if (state == scan_port_pkg::CAPTURE_INSTR) begin
                instruction_shift_reg <= scan_port_pkg::INSTR_CAPTURE;
            end else if (state == scan_port_pkg::SHIFT_INSTR) begin
                instruction_shift_reg <= {tdi_sync[1],
                                          instruction_shift_reg[3:1]};
            end else if (state == scan_port_pkg::UPDATE_INSTR) begin
                instr <= instruction_shift_reg;
            end
        end
    end

    // Chain selected by the two chain instructions
    assign sel_chain = (instr == scan_port_pkg::CODE_EXTEST) ||
                       (instr == scan_port_pkg::CODE_SAMPLE);
    // Identification path; reserved codes fall to bypass
    assign sel_id = (instr == scan_port_pkg::CODE_IDCODE);
    // Pins driven from the update latches
    assign drive_cells = (instr == scan_port_pkg::CODE_EXTEST) ||
                         (instr == scan_port_pkg::CODE_CLAMP);

    // Bypass bit captures zero, then shifts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_bit_pass_reg <= 1'b0;
        end else if (rise && state == scan_port_pkg::CAPTURE_DR) begin
            single_bit_pass_reg <= 1'b0;
        end else if (rise && state == scan_port_pkg::SHIFT_DR) begin
            single_bit_pass_reg <= tdi_sync[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            identification_shift_reg <= 32'h0;
        end else if (rise && state == scan_port_pkg::CAPTURE_DR) begin
            identification_shift_reg <= {scan_port_pkg::ID_VERSION,
                                         scan_port_pkg::ID_PART,
                                         scan_port_pkg::ID_MAKER,
                                         scan_port_pkg::ID_PRESENT_BIT};
        end else if (rise && state == scan_port_pkg::SHIFT_DR) begin
            identification_shift_reg <= {tdi_sync[1],
                                         identification_shift_reg[31:1]};
        end
    end

    // Capture functional inputs and core outputs only
    boundary_cell_chain u_chain (
        .clk(clk),
        .rst_n(rst_n),
        .capture(rise && sel_chain && state == scan_port_pkg::CAPTURE_DR),
        .shift(rise && sel_chain && state == scan_port_pkg::SHIFT_DR),
        .update(rise && sel_chain && state == scan_port_pkg::UPDATE_DR),
        .serial_in(tdi_sync[1]),
        .parallel_in({func_sync, core_out}),
        .serial_out(chain_so),
        .held(chain_held)
    );

    // Serial path selection
    always_comb begin
        if (state == scan_port_pkg::SHIFT_INSTR) begin
            serial_bit = instruction_shift_reg[0];
        end else if (sel_chain) begin
            serial_bit = chain_so;
        end else if (sel_id) begin
            serial_bit = identification_shift_reg[0];
        end else begin
            serial_bit = single_bit_pass_reg;
        end
    end

    // Serial output changes on falling test clock, enabled in shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (fall) begin
            tdo <= serial_bit;
            tdo_oe_n <= !(state == scan_port_pkg::SHIFT_INSTR ||
                          state == scan_port_pkg::SHIFT_DR);
        end
    end

    // Functional pin control; serial output exempt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe_n <= 1'b0;
        end else begin
            pin_out <= drive_cells ? chain_held[NO-1:0] : core_out;
            pin_oe_n <= (instr == scan_port_pkg::CODE_HIGHZ);
        end
    end

    // a_highz_pins: tristate follows instruction one cycle later
    a_highz_pins: assert property (@(posedge clk) disable iff (!rst_n)
        (instr == scan_port_pkg::CODE_HIGHZ) |=> pin_oe_n)
        else $error("pins not tristated under highz");
    a_extest_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (instr == scan_port_pkg::CODE_EXTEST) |=>
        pin_out == $past(chain_held[NO-1:0]))
        else $error("extest pins not from cells");
    a_clamp_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (instr == scan_port_pkg::CODE_CLAMP) |=>
        pin_out == $past(chain_held[NO-1:0]) && !pin_oe_n)
        else $error("clamp pins not held");
    a_bypass_path: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && state == scan_port_pkg::SHIFT_DR &&
         instr == scan_port_pkg::CODE_BYPASS) |=>
        tdo == $past(single_bit_pass_reg))
        else $error("bypass bit not on serial output");
    a_id_path: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && state == scan_port_pkg::SHIFT_DR && sel_id) |=>
        tdo == $past(identification_shift_reg[0]))
        else $error("id bit not on serial output");
    a_id_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (rise && state == scan_port_pkg::CAPTURE_DR) |=>
        identification_shift_reg[0] == 1'b1)
        else $error("id present bit not one");
    a_id_fields: assert property (@(posedge clk) disable iff (!rst_n)
        (rise && state == scan_port_pkg::CAPTURE_DR) |=>
        identification_shift_reg[27:12] == scan_port_pkg::ID_PART &&
        identification_shift_reg[31:28] == scan_port_pkg::ID_VERSION &&
        identification_shift_reg[11:1] == scan_port_pkg::ID_MAKER)
        else $error("id fields wrong");
    a_chain_path: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && state == scan_port_pkg::SHIFT_DR && sel_chain) |=>
        tdo == $past(chain_so))
        else $error("chain not on serial output");
    a_tdo_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && state == scan_port_pkg::RUN_IDLE) |=> tdo_oe_n)
        else $error("serial output driven outside shift");
    a_trst_home: assert property (@(posedge clk) disable iff (!rst_n)
        !trst_sync[1] |=> state == scan_port_pkg::TEST_LOGIC_RESET)
        else $error("test reset did not reach reset state");
endmodule

// file: include/scan_port_pkg.sv
package scan_port_pkg;
    // Instruction register width and codes
    localparam int INSTR_WIDTH = 4;
    localparam logic [3:0] CODE_EXTEST = 4'h0;
    localparam logic [3:0] CODE_SAMPLE = 4'h1;
    localparam logic [3:0] CODE_IDCODE = 4'h2;
    localparam logic [3:0] CODE_CLAMP = 4'h3;
    localparam logic [3:0] CODE_HIGHZ = 4'h4;
    localparam logic [3:0] CODE_BYPASS = 4'hf;
    // Value after test reset: IDCODE per the standard
    localparam logic [3:0] INSTR_RESET = 4'h2;
    // Fixed capture pattern of the instruction register (low bits 01)
    localparam logic [3:0] INSTR_CAPTURE = 4'h1;
    // Identification register layout
    localparam int ID_WIDTH = 32;
    localparam int ID_VERSION_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam logic ID_PRESENT_BIT = 1'b1;
    // Identity values; arbitrary neutral values
    localparam logic [3:0] ID_VERSION = 4'h5;
    localparam logic [15:0] ID_PART = 16'h1234;
    localparam logic [10:0] ID_MAKER = 11'h2aa;
    // Boundary chain geometry
    localparam int CHAIN_INPUTS = 8;
    localparam int CHAIN_OUTPUTS = 8;
    localparam int CHAIN_LENGTH = 16;
    // Test clock figures
    localparam int TEST_CLK_NS = 100;
    localparam int SYS_CLK_NS = 10;
    localparam int SYNC_STAGES = 2;
    // Test access controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR,
        EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_INSTR,
        CAPTURE_INSTR, SHIFT_INSTR, EXIT1_INSTR, PAUSE_INSTR,
        EXIT2_INSTR, UPDATE_INSTR
    } tap_state_type;
endpackage

// file: core/boundary_cell_chain.sv
`timescale 1ns/10ps
// Boundary chain: capture, shift and update stages of every cell
module boundary_cell_chain (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic serial_in,
    input wire logic [scan_port_pkg::CHAIN_LENGTH-1:0] parallel_in,
    output logic serial_out,
    output logic [scan_port_pkg::CHAIN_LENGTH-1:0] held
);
    logic [scan_port_pkg::CHAIN_LENGTH-1:0] cells;

    // Per-cell shift stage; highest cell sits nearest the serial input
    genvar i;
    generate
        for (i = 0; i < scan_port_pkg::CHAIN_LENGTH; i++) begin : g_cell
            logic upstream;
            if (i == scan_port_pkg::CHAIN_LENGTH - 1) begin : g_top
                assign upstream = serial_in;
            end else begin : g_mid
                assign upstream = cells[i+1];
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cells[i] <= 1'b0;
                end else if (capture) begin
                    cells[i] <= parallel_in[i];
                end else if (shift) begin
                    cells[i] <= upstream;
                end
            end
            // Update latch holds pin values steady during shifting
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    held[i] <= 1'b0;
                end else if (update) begin
                    held[i] <= cells[i];
                end
            end
        end
    endgenerate

    assign serial_out = cells[0];
endmodule

// file: testbench/scan_controller_model.sv
`timescale 1ns/10ps
// Test controller on the far side of the scan link
module scan_controller_model (
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    // Link idles with tck low; the clock only runs inside sequences
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // sample on rise
    // One tck period of 16 clk: tdo sampled just before the rise
    task automatic pulse(input logic m, input logic d, output logic q,
                         output logic oe);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk);
        q = tdo;
        oe = tdo_oe_n;
        tck <= 1'b1;
        repeat (8) @(posedge clk);
        tck <= 1'b0;
    endtask

    // standard state walk
    // From Run-Idle through a shift of n bits back to Run-Idle;
    // tdi toggles outside shifts so a stale bit is never reused
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout,
                        output logic oe_bad);
        logic q;
        logic oe;
        dout = '0;
        oe_bad = 1'b0;
        @(posedge clk);
        pulse(1'b1, ~tdi, q, oe);
        if (ir) pulse(1'b1, ~tdi, q, oe);
        pulse(1'b0, ~tdi, q, oe);
        pulse(1'b0, ~tdi, q, oe);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q, oe);
            dout[i] = q;
            oe_bad = oe_bad | oe;
        end
        pulse(1'b1, ~tdi, q, oe);
        pulse(1'b0, ~tdi, q, oe);
    endtask

    // reset by pin and tms
    // Pin reset held 80 ns, then five tms-high clocks, then to Run-Idle
    task automatic tap_reset();
        logic q;
        logic oe;
        @(posedge clk);
        trst_n <= 1'b0;
        repeat (8) @(posedge clk);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 5; i++) pulse(1'b1, ~tdi, q, oe);
        pulse(1'b0, ~tdi, q, oe);
    endtask
endmodule

// file: testbench/boundary_scan_test_port_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the scan test port
module boundary_scan_test_port_tb;
    logic clk;
    logic nrst;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic [scan_port_pkg::CHAIN_INPUTS-1:0] func_in;
    logic [scan_port_pkg::CHAIN_OUTPUTS-1:0] core_out;
    logic [scan_port_pkg::CHAIN_OUTPUTS-1:0] pin_out;
    logic pin_oe_n;
    logic tdo;
    logic tdo_oe_n;
    int num_errors;
    int cmp_count;
    logic [31:0] got;
    logic oe_bad;
    localparam logic [31:0] ID_EXP = {scan_port_pkg::ID_VERSION,
        scan_port_pkg::ID_PART, scan_port_pkg::ID_MAKER,
        scan_port_pkg::ID_PRESENT_BIT};

    boundary_scan_test_port DUT (.clk(clk), .nrst(nrst), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .func_in(func_in),
        .core_out(core_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n));

    scan_controller_model ctl (.clk(clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

    // Clock generator, 10 ns period
    always #5 clk = ~clk;

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        cmp_count++;
        if (act !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Instruction load; capture pattern comes out first
    task automatic load_code(input logic [3:0] code);
        ctl.scan(1'b1, 4, {28'h0, code}, got, oe_bad);
        check(32'(got[3:0]), 32'(scan_port_pkg::INSTR_CAPTURE));
        check(32'(oe_bad), 32'h0);
    endtask

    task automatic test_idcode(input logic load);
        if (load) load_code(scan_port_pkg::CODE_IDCODE);
        ctl.scan(1'b0, 32, 32'h0, got, oe_bad);
        check(got, ID_EXP);
        check(32'(tdo_oe_n), 32'h1);
    endtask

    task automatic test_sample();
        @(posedge clk);
        func_in <= 8'hc3;
        core_out <= 8'h3c;
        load_code(scan_port_pkg::CODE_SAMPLE);
        ctl.scan(1'b0, 16, 32'h0000a55a, got, oe_bad);
        check(got, 32'h0000c33c);
        check(32'(pin_out), 32'h3c);
        check(32'(pin_oe_n), 32'h0);
    endtask

    task automatic test_extest();
        load_code(scan_port_pkg::CODE_EXTEST);
        check(32'(pin_out), 32'h5a);
        check(32'(pin_oe_n), 32'h0);
        ctl.scan(1'b0, 16, 32'h00000f96, got, oe_bad);
        check(32'(got[15:8]), 32'hc3);
        check(32'(pin_out), 32'h96);
    endtask

    task automatic test_bypass();
        logic [3:0] codes [4];
        // Clamp again after bypass: held cells must still reach pins
        codes = '{scan_port_pkg::CODE_CLAMP, scan_port_pkg::CODE_HIGHZ,
                  scan_port_pkg::CODE_BYPASS, scan_port_pkg::CODE_CLAMP};
        for (int i = 0; i < 4; i++) begin
            load_code(codes[i]);
            ctl.scan(1'b0, 8, 32'h000000b6, got, oe_bad);
            check(got, 32'h0000006c);
            check(32'(oe_bad), 32'h0);
            check(32'(pin_oe_n),
                32'(codes[i] == scan_port_pkg::CODE_HIGHZ));
            if (codes[i] != scan_port_pkg::CODE_HIGHZ) begin
                check(32'(pin_out), (codes[i] == scan_port_pkg::CODE_CLAMP)
                    ? 32'h96 : 32'h3c);
            end
        end
    endtask

    // test reset back to identification and normal pins
    task automatic test_reset();
        ctl.tap_reset();
        check(32'(pin_oe_n), 32'h0);
        check(32'(pin_out), 32'h3c);
        test_idcode(1'b0);
    endtask

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        func_in = '0;
        core_out = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        // Controller starts in its reset state; walk it to Run-Idle
        ctl.tap_reset();
        test_idcode(1'b0);
        test_sample();
        test_extest();
        test_bypass();
        test_reset();
        test_idcode(1'b1);
        stop_test();
    end

    // Watchdog: the run needs about 47 us; nearly thirteen times that is a hang
    initial begin
        #600us;
        num_errors++;
        stop_test();
    end
endmodule
